//--- core/ftc_pkg.sv
// package for the fast timer compare/pwm block: register map, fields, timing
package ftc_pkg;
  // register byte addresses (word aligned)
  localparam logic [7:0] FTC_ADDR_CONTROL = 8'h30;
  localparam logic [7:0] FTC_ADDR_COUNT   = 8'h34;
  localparam logic [7:0] FTC_ADDR_MATCH   = 8'h38;
  localparam logic [7:0] FTC_ADDR_LIMIT   = 8'h3C;
  localparam logic [7:0] FTC_ADDR_SPECIAL = 8'h40;
  localparam logic [7:0] FTC_ADDR_FLAGS   = 8'h44;
  localparam logic [7:0] FTC_ADDR_MASK    = 8'h48;
  // control fields
  localparam int FTC_CTL_CLEAR  = 7;
  localparam int FTC_CTL_MOD    = 6;
  localparam int FTC_CTL_ACT_HI = 5;
  localparam int FTC_CTL_ACT_LO = 4;
  // special function bits
  localparam int FTC_SPC_FORCE  = 2;
  localparam int FTC_SPC_PSRST  = 1;
  // flag and mask bit positions
  localparam int FTC_FLG_MATCH  = 6;
  localparam int FTC_FLG_OVF    = 2;
  // reset values
  localparam logic [7:0] FTC_RST_BYTE  = 8'h00;
  localparam logic [7:0] FTC_RST_LIMIT = 8'hFF;
  // source select codes
  localparam logic [3:0] FTC_SEL_STOP = 4'h0;
  localparam logic [3:0] FTC_SEL_SYS  = 4'h5;
  // fast clock ratio and prescaler widths
  localparam int FTC_FAST_RATIO = 16;
  localparam int FTC_FAST_BITS  = 4;
  localparam int FTC_PRE_BITS   = 10;
  localparam logic [7:0] FTC_ZERO = 8'h00;
  localparam logic [7:0] FTC_TOP  = 8'hFF;

  // output action encodings
  typedef enum logic [1:0] {
    FTC_ACT_OFF    = 2'b00,
    FTC_ACT_TOGGLE = 2'b01,
    FTC_ACT_CLEAR  = 2'b10,
    FTC_ACT_SET    = 2'b11
  } ftc_act_t;

  // avalon slave request
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ftc_req_t;

  // avalon slave answer
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
  } ftc_rsp_t;

  // bus handshake phase
  typedef enum logic [0:0] {
    FTC_BUS_IDLE = 1'b0,
    FTC_BUS_DONE = 1'b1
  } ftc_bus_t;

  // whole block state
  typedef struct packed {
    ftc_bus_t                  bus;
    ftc_rsp_t                  rsp;
    logic [7:0]                ctl;
    logic [7:0]                cnt;
    logic [7:0]                match;
    logic [7:0]                hold;
    logic                      hold_pend;
    logic [7:0]                limit;
    logic [7:0]                flags;
    logic [7:0]                mask;
    logic [FTC_PRE_BITS-1:0]   pre;
    logic [FTC_FAST_BITS-1:0]  fast;
    logic                      cnt_wr;
    logic [7:0]                cnt_wval;
    logic                      hit;
    logic                      pin;
    logic                      pin_oe;
  } ftc_state_t;
endpackage

//--- core/ftc_timer.sv
// fast timer with one compare channel, pwm mode and avalon register slave
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ns
module ftc_timer (
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst,
  // avalon-mm slave
  input  wire ftc_pkg::ftc_req_t avs_req,
  output ftc_pkg::ftc_rsp_t    avs_rsp,
  // port pin
  input  wire logic            port_dir_one,
  output logic                 port_pin_one_out,
  output logic                 port_pin_one_oe,
  // flag outputs toward the shared interrupt logic
  output logic [7:0]           timer_flags,
  output logic [7:0]           timer_mask
);
  import ftc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // overview
  //
  // the whole block is one packed state word; a single combinational process
  // works out its next value and a single clocked process registers it, so
  // every output leaves straight from a flip-flop and nothing else holds state.
  //
  // register access costs one wait cycle. a request is taken while the bus
  // phase is idle; waitrequest is driven low for exactly the next cycle and
  // the master sees it low at the following rising edge. read data are
  // captured at the taking edge so they already stand when the master looks.
  // writes are applied only at the edge where waitrequest is seen low, which
  // keeps the register change in step with the master's view of completion.
  //
  // the sixteen-times fast clock is not a real clock here. it is stood in for
  // by a small phase counter, and the fast source codes advance the count once
  // per system cycle. this trades true sub-cycle resolution for a design with
  // a single clock domain and no crossing logic at all.
  //
  // the count path gives priority, in order, to a pending software write, to
  // a clear after a match, and then to the selected tick. a written value
  // never produces a match, because the match test only runs on a tick.
  //
  // limitation: the count write and the compare value share no interlock;
  // software that rewrites both in quick succession sees the later one win.
  //
  // the shared interrupt logic is outside this block; it only receives the
  // flag and mask bytes and decides on its own whether to raise anything.
  ////////////////////////////////////////////////////////////////////////////

  ftc_state_t s_q;
  ftc_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // decode a word address against one register
  function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] r);
    hit_addr = (a == r);
  endfunction

  // tick for a source select; fast codes tick on every system cycle, like the system code
  function automatic logic sel_tick(input logic [3:0] sel,
                                    input logic [FTC_PRE_BITS-1:0] pre);
    logic [FTC_PRE_BITS-1:0] ones;
    int unsigned n;
    ones = '0;
    n = 0;
    sel_tick = 1'b0;
    if (sel == FTC_SEL_STOP) begin
      sel_tick = 1'b0;
    end else if (sel <= FTC_SEL_SYS) begin
      sel_tick = 1'b1;
    end else begin
      n = 32'(sel - FTC_SEL_SYS);
      for (int i = 0; i < FTC_PRE_BITS; i++) begin
        if (i < n) begin
          ones[i] = 1'b1;
        end
      end
      sel_tick = ((pre & ones) == ones);
    end
  endfunction

  // fast steps per system cycle: 16, 8, 4, 2 for codes 1..4
  function automatic logic [FTC_FAST_BITS:0] fast_steps(input logic [3:0] sel);
    fast_steps = '0;
    if (sel != FTC_SEL_STOP && sel < FTC_SEL_SYS) begin
      fast_steps = (FTC_FAST_BITS+1)'(FTC_FAST_RATIO >> (sel - 4'h1));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic        wr;
    logic        rd;
    logic        pwm;
    logic        tick;
    logic [7:0]  top;
    logic [7:0]  wd;
    logic [7:0]  rdv;
    logic [4:0]  steps;
    logic        hit_now;
    logic        wrap;
    logic        force_w;
    logic        take;
    ftc_act_t    act;
    s_d     = s_q;
    take    = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    pwm     = s_q.ctl[FTC_CTL_MOD];
    act     = ftc_act_t'(s_q.ctl[FTC_CTL_ACT_HI:FTC_CTL_ACT_LO]);
    top     = pwm ? s_q.limit : FTC_TOP;
    wd      = avs_req.writedata[7:0];
    rdv     = FTC_RST_BYTE;
    tick    = sel_tick(s_q.ctl[3:0], s_q.pre);
    steps   = fast_steps(s_q.ctl[3:0]);
    hit_now = 1'b0;
    wrap    = 1'b0;
    force_w = 1'b0;

    // bus: one wait cycle, answer with waitrequest low on the second
    // reads are captured when taken; writes land where the master sees the
    // answer, so a register never changes before the master counts it done
    s_d.rsp.waitrequest = 1'b1;
    s_d.rsp.response    = 2'b00;
    case (s_q.bus)
      FTC_BUS_IDLE: begin
        if (avs_req.read || avs_req.write) begin
          s_d.bus             = FTC_BUS_DONE;
          s_d.rsp.waitrequest = 1'b0;
          take                = 1'b1;
          rd                  = avs_req.read;
        end
      end
      FTC_BUS_DONE: begin
        s_d.bus = FTC_BUS_IDLE;
        // the request still stands here, held by the master
        wr      = avs_req.write && avs_req.byteenable[0];
      end
      default: begin
        s_d.bus = FTC_BUS_IDLE;
      end
    endcase

    // read mux; unmapped reads return zero with a decode error
    if (hit_addr(avs_req.address, FTC_ADDR_CONTROL)) rdv = s_q.ctl;
    else if (hit_addr(avs_req.address, FTC_ADDR_COUNT)) rdv = s_q.cnt;
    else if (hit_addr(avs_req.address, FTC_ADDR_MATCH)) begin
      rdv = s_q.hold_pend ? s_q.hold : s_q.match;
    end
    else if (hit_addr(avs_req.address, FTC_ADDR_LIMIT)) rdv = s_q.limit;
    else if (hit_addr(avs_req.address, FTC_ADDR_SPECIAL)) rdv = FTC_RST_BYTE;
    else if (hit_addr(avs_req.address, FTC_ADDR_FLAGS)) rdv = s_q.flags;
    else if (hit_addr(avs_req.address, FTC_ADDR_MASK)) rdv = s_q.mask;
    else if (take) s_d.rsp.response = 2'b11;
    if (rd) s_d.rsp.readdata = {24'h000000, rdv};

    // fast phase counter: the sixteen-times clock modelled as sub-steps
    s_d.fast = s_q.fast + steps[FTC_FAST_BITS-1:0];

    // count path; a pending software write lands this cycle, no match check
    // the one-cycle delay on a write stands in for the clock domain crossing
    // that the real counter has; keeping it means software timing matches.
    // clearing after a match only applies in normal mode, pwm has its own top.
    // the match test looks at the value being counted into, so a count that
    // reaches the compare value by a write is never seen as an event.
    s_d.hit = 1'b0;
    if (s_q.cnt_wr) begin
      s_d.cnt = s_q.cnt_wval;
    end else if (s_q.hit && s_q.ctl[FTC_CTL_CLEAR] && !pwm) begin
      s_d.cnt = FTC_ZERO;
    end else if (tick) begin
      if (s_q.cnt == top) begin
        s_d.cnt = FTC_ZERO;
        wrap    = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
      hit_now = (s_d.cnt == s_q.match);
    end
    s_d.hit = hit_now;

    // flags, set wins over software clear (write one to clear)
    // the clear is applied first and the hardware set after it, so an event
    // that falls in the same cycle as the clear is never lost.
    // both flags behave the same in normal and pwm mode.
    if (wr && hit_addr(avs_req.address, FTC_ADDR_FLAGS)) begin
      s_d.flags = s_q.flags & ~wd;
    end
    if (s_q.hit) s_d.flags[FTC_FLG_MATCH] = 1'b1;
    if (wrap)    s_d.flags[FTC_FLG_OVF]   = 1'b1;

    // pwm double buffer: copy when count reaches the limit
    // copying only at the top keeps every pulse whole; a new duty value that
    // arrives mid-period waits for the period to end instead of cutting it.
    // leaving pwm with a value still held copies it at once, since normal
    // mode has no period boundary to wait for.
    if (pwm && s_q.hold_pend && s_q.cnt == s_q.limit) begin
      s_d.match     = s_q.hold;
      s_d.hold_pend = 1'b0;
    end
    if (!pwm && s_q.hold_pend) begin
      s_d.match     = s_q.hold;
      s_d.hold_pend = 1'b0;
    end

    // register writes
    s_d.cnt_wr = 1'b0;
    if (wr) begin
      if (hit_addr(avs_req.address, FTC_ADDR_CONTROL)) s_d.ctl = wd;
      if (hit_addr(avs_req.address, FTC_ADDR_COUNT)) begin
        s_d.cnt_wr   = 1'b1;
        s_d.cnt_wval = wd;
      end
      if (hit_addr(avs_req.address, FTC_ADDR_MATCH)) begin
        if (pwm) begin
          s_d.hold      = wd;
          s_d.hold_pend = 1'b1;
        end else begin
          s_d.match     = wd;
          s_d.hold      = wd;
          s_d.hold_pend = 1'b0;
        end
      end
      if (hit_addr(avs_req.address, FTC_ADDR_LIMIT)) s_d.limit = wd;
      if (hit_addr(avs_req.address, FTC_ADDR_MASK))  s_d.mask  = wd;
      if (hit_addr(avs_req.address, FTC_ADDR_SPECIAL)) begin
        force_w = wd[FTC_SPC_FORCE] && !pwm;
      end
    end

    // prescaler; a reset write restarts it, the bit itself is never stored
    // the prescaler runs freely on every cycle so that a later change of the
    // source select does not restart the division; software that needs a
    // known phase uses the reset bit before starting the timer.
    if (wr && hit_addr(avs_req.address, FTC_ADDR_SPECIAL) && wd[FTC_SPC_PSRST]) begin
      s_d.pre  = '0;
      s_d.fast = '0;
    end else begin
      s_d.pre = s_q.pre + FTC_PRE_BITS'(1);
    end

    // pin action
    // normal mode acts on a registered match or a forced one; pwm sets and
    // clears around the match and the zero count. the two end values of the
    // compare word pin the output to a level so no one-cycle sliver appears.
    // the pin level is kept while disconnected so reconnecting shows the last
    // level the compare logic decided on.
    if (!pwm) begin
      if (s_q.hit || force_w) begin
        case (act)
          FTC_ACT_TOGGLE: s_d.pin = ~s_q.pin;
          FTC_ACT_CLEAR:  s_d.pin = 1'b0;
          FTC_ACT_SET:    s_d.pin = 1'b1;
          default:        s_d.pin = s_q.pin;
        endcase
      end
    end else if (act[1]) begin
      if (s_q.match == FTC_ZERO) begin
        s_d.pin = act[0];
      end else if (s_q.match == s_q.limit) begin
        s_d.pin = ~act[0];
      end else if (s_q.hit) begin
        s_d.pin = act[0];
      end else if (s_q.cnt == FTC_ZERO) begin
        s_d.pin = ~act[0];
      end
    end
    // drive only when an action is connected and the port is an output
    s_d.pin_oe = port_dir_one && (act != FTC_ACT_OFF) &&
                 !(pwm && !act[1]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  // reset holds waitrequest high so the master never sees an answer before
  // the block is out of reset; the period limit starts at the full count.
  // only constants are loaded on reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q                 <= '0;
      s_q.rsp.waitrequest <= 1'b1;
      s_q.limit           <= FTC_RST_LIMIT;
      s_q.ctl             <= FTC_RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  // no logic sits between the state word and the ports, so nothing here can
  // glitch on its way out of the block.
  assign avs_rsp          = s_q.rsp;
  assign port_pin_one_out = s_q.pin;
  assign port_pin_one_oe  = s_q.pin_oe;
  assign timer_flags      = s_q.flags;
  assign timer_mask       = s_q.mask;
endmodule

//--- sim/ftc_chk.sv
// bus, pin and flag properties for the fast timer block
`timescale 1ns/1ns
module ftc_chk
  import ftc_pkg::*;
(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // register bus
  input wire ftc_pkg::ftc_req_t avs_req,
  input wire ftc_pkg::ftc_rsp_t avs_rsp,
  // pin and flags
  input wire logic              port_dir_one,
  input wire logic              port_pin_one_out,
  input wire logic              port_pin_one_oe,
  input wire logic [7:0]        timer_flags,
  input wire logic [7:0]        timer_mask
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic req_on;
  // a request of either kind
  assign req_on = avs_req.read | avs_req.write;
  ////////////////////////////////////////////////////////////////////////////////
  property p_ans_one;
    !avs_rsp.waitrequest |=> avs_rsp.waitrequest;
  endproperty
  a_ans_one: assert property (p_ans_one) else $error("answer longer than one cycle");
  property p_take;
    $rose(req_on) |=> !avs_rsp.waitrequest;
  endproperty
  a_take: assert property (p_take) else $error("request not answered next cycle");
  property p_no_spur;
    !avs_rsp.waitrequest |-> $past(req_on);
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("answer without request");
  property p_upper;
    !avs_rsp.waitrequest && $past(avs_req.read) |-> avs_rsp.readdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  // the port keeps the pin once its direction has been input for two cycles
  property p_pin_dir;
    !port_dir_one ##1 !port_dir_one |-> !port_pin_one_oe;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin driven while input");
  property p_ovf_keep;
    timer_flags[FTC_FLG_OVF] && !avs_req.write |=> timer_flags[FTC_FLG_OVF];
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag lost");
  property p_mat_keep;
    timer_flags[FTC_FLG_MATCH] && !avs_req.write |=> timer_flags[FTC_FLG_MATCH];
  endproperty
  a_mat_keep: assert property (p_mat_keep) else $error("match flag lost");
  property p_mask_src;
    !$stable(timer_mask) |-> $past(avs_req.write) && $past(avs_req.address) == FTC_ADDR_MASK;
  endproperty
  a_mask_src: assert property (p_mask_src) else $error("mask changed without write");
  c_match: cover property ($rose(timer_flags[FTC_FLG_MATCH]));
  c_ovf: cover property ($rose(timer_flags[FTC_FLG_OVF]));
  c_unmap: cover property (avs_rsp.response == 2'b11);
endmodule

//--- sim/ftc_pin_model.sv
// far-side pin model: level of the shared pin as the outside sees it
`timescale 1ns/1ns
module ftc_pin_model (
  // clock
  input  wire logic sys_clk,
  // drive from the block
  input  wire logic drv,
  input  wire logic oe,
  // resolved level
  output logic      lvl
);
  logic alt_q = 1'b0;
  // an undriven pin wanders so a stale level never passes
  always_ff @(posedge sys_clk) alt_q <= ~alt_q;
  assign lvl = oe ? drv : alt_q;
endmodule

//--- sim/fast_timer_compare_pwm_test.sv
// self-checking bench for the fast timer compare/pwm block
`timescale 1ns/1ns
module fast_timer_compare_pwm_test;
  import ftc_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst     = 1'b1;
  ftc_req_t   req     = '{byteenable: 4'hF, default: '0};
  ftc_rsp_t   rsp;
  logic       dir     = 1'b1;
  logic       pin_out, pin_oe, lvl;
  logic [7:0] flags, mask;
  logic [7:0] rnd     = 8'h45;
  logic [9:0] exp_q[$];
  int         failures = 0;
  int         n_checks = 0;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  ftc_timer dut_u (.sys_clk(sys_clk), .rst(rst), .avs_req(req), .avs_rsp(rsp),
    .port_dir_one(dir), .port_pin_one_out(pin_out), .port_pin_one_oe(pin_oe),
    .timer_flags(flags), .timer_mask(mask));
  ftc_pin_model pin_u (.sys_clk(sys_clk), .drv(pin_out), .oe(pin_oe), .lvl(lvl));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req.address <= a;
    req.read <= ~w;
    req.write <= w;
    req.writedata <= {24'h0, d};
    do @(posedge sys_clk); while (rsp.waitrequest !== 1'b0);
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [9:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // pin sampled mid-cycle, well away from the launching edge
  task automatic pin_is(input logic e);
    @(negedge sys_clk);
    chk("pin", {8'h0, pin_oe, lvl}, {8'h0, 1'b1, e});
  endtask
  task automatic pwm_hold(input logic [7:0] c, input logic [7:0] m, input logic e);
    wr(FTC_ADDR_CONTROL, c);
    wr(FTC_ADDR_MATCH, m);
    run(40);
    repeat (16) pin_is(e);
  endtask
  task automatic conclude();
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // read answers compared against the oldest note
  always @(posedge sys_clk) begin
    if (req.read && rsp.waitrequest === 1'b0)
      chk("readdata", {rsp.response, rsp.readdata[7:0]}, exp_q.pop_front());
  end
  // hang guard
  initial begin
    run(6000);
    failures++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    run(20);
    rst <= 1'b0;
    rd(FTC_ADDR_CONTROL, 10'h000);
    rd(FTC_ADDR_LIMIT, {2'b00, FTC_RST_LIMIT});
    rd(8'h50, 10'h300);
    req.byteenable <= 4'h0;
    wr(FTC_ADDR_CONTROL, 8'hFF);
    req.byteenable <= 4'hF;
    rd(FTC_ADDR_CONTROL, 10'h000);
    rnd = lfsr(rnd);
    wr(FTC_ADDR_COUNT, rnd);
    rd(FTC_ADDR_COUNT, {2'b00, rnd});
    run(5);
    rd(FTC_ADDR_COUNT, {2'b00, rnd});
    wr(FTC_ADDR_MATCH, rnd);
    rd(FTC_ADDR_FLAGS, 10'h000);
    wr(FTC_ADDR_MASK, 8'h04);
    rd(FTC_ADDR_MASK, 10'h004);
    chk("mask", {2'b00, mask}, 10'h004);
    // clear-on-match keeps the count from wrapping, so no overflow
    for (int act = 3; act >= 2; act--) begin
      rnd = lfsr(rnd);
      wr(FTC_ADDR_CONTROL, 8'h00);
      wr(FTC_ADDR_COUNT, 8'h00);
      wr(FTC_ADDR_MATCH, 8'h08 + {3'h0, rnd[4:0]});
      wr(FTC_ADDR_FLAGS, 8'hFF);
      wr(FTC_ADDR_CONTROL, {2'b10, act[1:0], FTC_SEL_SYS});
      run(60);
      wr(FTC_ADDR_CONTROL, {2'b00, act[1:0], FTC_SEL_STOP});
      rd(FTC_ADDR_FLAGS, 10'h040);
      pin_is(act[0]);
    end
    wr(FTC_ADDR_FLAGS, 8'hFF);
    wr(FTC_ADDR_CONTROL, 8'h10);
    wr(FTC_ADDR_SPECIAL, 8'h04);
    pin_is(1'b1);
    rd(FTC_ADDR_SPECIAL, 10'h000);
    rd(FTC_ADDR_FLAGS, 10'h000);
    wr(FTC_ADDR_SPECIAL, 8'h02);
    rd(FTC_ADDR_SPECIAL, 10'h000);
    dir <= 1'b0;
    run(3);
    chk("oe", {9'h0, pin_oe}, 10'h000);
    dir <= 1'b1;
    wr(FTC_ADDR_CONTROL, 8'h00);
    wr(FTC_ADDR_MATCH, 8'hE0);
    wr(FTC_ADDR_COUNT, 8'hF0);
    wr(FTC_ADDR_FLAGS, 8'hFF);
    wr(FTC_ADDR_CONTROL, {4'h0, FTC_SEL_SYS});
    run(40);
    wr(FTC_ADDR_CONTROL, 8'h00);
    rd(FTC_ADDR_FLAGS, 10'h004);
    chk("oe", {9'h0, pin_oe}, 10'h000);
    // stopped pwm never reaches the limit, so the write stays held
    wr(FTC_ADDR_CONTROL, 8'h60);
    wr(FTC_ADDR_MATCH, 8'h07);
    rd(FTC_ADDR_MATCH, 10'h007);
    wr(FTC_ADDR_COUNT, 8'h00);
    wr(FTC_ADDR_LIMIT, 8'h0F);
    pwm_hold(8'h65, 8'h00, 1'b0);
    pwm_hold(8'h65, 8'h0F, 1'b1);
    wr(FTC_ADDR_FLAGS, 8'hFF);
    run(40);
    rd(FTC_ADDR_FLAGS, 10'h044);
    pwm_hold(8'h75, 8'h0F, 1'b0);
    conclude();
  end
endmodule
bind ftc_timer ftc_chk chk_u (.sys_clk(sys_clk), .rst(rst), .avs_req(avs_req),
  .avs_rsp(avs_rsp), .port_dir_one(port_dir_one), .port_pin_one_out(port_pin_one_out),
  .port_pin_one_oe(port_pin_one_oe), .timer_flags(timer_flags), .timer_mask(timer_mask));
